// file: rtl/cache_ctl_write_buffer_regs.vh
// constants for the bus-side cache control and write buffer
// assumes one clock, synchronous inputs, included by the design file only
`ifndef CACHE_CTL_WRITE_BUFFER_REGS_VH
`define CACHE_CTL_WRITE_BUFFER_REGS_VH
`define WB_DEPTH_DEF    4
`define WB_PTR_W_DEF    2
`define IDX_W_DEF       4
`define PWT_BIT         3
`define PCD_BIT         4
`define LANES_ALL       4'hf
`define LANES_NONE      4'h0
`define LANES_LO16      4'h3
`define LANES_HI16      4'hc
`define LINE_LAST_WORD  2'h3
`endif

// file: rtl/cache_ctl_write_buffer.v
// cache tag/valid control, bus sequencer with dynamic sizing and posted write buffer
// assumes the core holds a request until acknowledged and a partner bus controller
`timescale 1ns/1ps
`include "cache_ctl_write_buffer_regs.vh"
module cache_ctl_write_buffer #(
  parameter IDX_W    = `IDX_W_DEF,
  parameter WB_DEPTH = `WB_DEPTH_DEF,
  parameter WB_PTR_W = `WB_PTR_W_DEF
)(
  input  wire        ref_clk_i,
  input  wire        sys_rst_i,
  input  wire        req_valid_i,
  input  wire        req_write_i,
  input  wire        req_io_i,
  input  wire        req_rep_io_i,
  input  wire        req_lock_i,
  input  wire [31:0] req_addr_i,
  input  wire [31:0] req_data_i,
  input  wire [3:0]  req_be_i,
  input  wire        paging_en_i,
  input  wire        cache_enable_i,
  input  wire [4:0]  pte_flags_i,
  input  wire [4:0]  page_base_flags_i,
  input  wire        addr20_mask_n_i,
  input  wire        flush_n_i,
  input  wire        rdy_n_i,
  input  wire        burst_ready_n_i,
  input  wire        backoff_n_i,
  input  wire        hold_i,
  input  wire        addr_float_req_i,
  input  wire        snoop_addr_strobe_n_i,
  input  wire [31:4] snoop_addr_i,
  input  wire        line_cacheable_n_i,
  input  wire        bus_width16_n_i,
  input  wire        bus_width8_n_i,
  input  wire [31:0] data_i,
  output reg         req_ack_o,
  output reg         rd_hit_o,
  output reg  [31:0] rd_data_o,
  output reg         cache_update_o,
  output reg         ads_o,
  output reg  [31:2] addr_o,
  output reg         addr_oe_o,
  output reg  [3:0]  be_o,
  output reg         wr_o,
  output reg         mem_io_o,
  output reg  [31:0] data_o,
  output reg         data_oe_o,
  output reg         bus_lock_o,
  output reg         page_write_through_o,
  output reg         page_cache_disable_o,
  output reg         attr_oe_o,
  output reg         hold_ack_o
);
  localparam ST_IDLE = 1'b0;
  localparam ST_ACT  = 1'b1;
  localparam LINES   = 1 << IDX_W;
  localparam TAG_W   = 28 - IDX_W;
  localparam [WB_PTR_W:0] WB_FULL = WB_DEPTH[WB_PTR_W:0];

  reg              bus_st_r;
  reg [LINES-1:0]  valid_r;
  reg [TAG_W-1:0]  tag_mem [0:LINES-1];
  reg [31:2]       wb_addr [0:WB_DEPTH-1];
  reg [31:0]       wb_data [0:WB_DEPTH-1];
  reg [3:0]        wb_be   [0:WB_DEPTH-1];
  reg [3:0]        wb_attr [0:WB_DEPTH-1];
  reg [WB_PTR_W-1:0] wb_rd_r;
  reg [WB_PTR_W-1:0] wb_wr_r;
  reg [WB_PTR_W:0]   wb_cnt_r;
  reg [WB_PTR_W:0]   miss_cnt_r;
  reg              reorder_used_r;
  reg              w8_r;
  reg              w16_r;
  reg              backoff_n_r;
  reg              wait_r;
  reg [3:0]        rem_r;
  reg [1:0]        word_r;
  reg              fill_r;
  reg              fillc_r;
  reg              cur_ack_r;
  reg              cur_lockw_r;
  reg [31:0]       rd_acc_r;
  integer          i;

  // masked physical address feeds both lookup and the bus
  wire [31:0] req_pa = {req_addr_i[31:21], req_addr_i[20] & addr20_mask_n_i, req_addr_i[19:0]};
  wire [IDX_W-1:0] req_idx = req_pa[4+IDX_W-1:4];
  wire [TAG_W-1:0] req_tag = req_pa[31:4+IDX_W];
  wire req_hit = valid_r[req_idx] & (tag_mem[req_idx] == req_tag) & ~req_io_i;
  wire [IDX_W-1:0] sn_idx = snoop_addr_i[4+IDX_W-1:4];
  wire sn_hit = ~snoop_addr_strobe_n_i & valid_r[sn_idx] & (tag_mem[sn_idx] == snoop_addr_i[31:4+IDX_W]);
  wire [IDX_W-1:0] cur_idx = addr_o[4+IDX_W-1:4];
  wire paged = paging_en_i & ~req_io_i;
  wire pwt_req = paged ? pte_flags_i[`PWT_BIT] : page_base_flags_i[`PWT_BIT];
  wire pcd_req = (paged ? pte_flags_i[`PCD_BIT] : page_base_flags_i[`PCD_BIT]) | ~cache_enable_i;
  wire wb_empty = (wb_cnt_r == {(WB_PTR_W+1){1'b0}});
  wire wb_full = (wb_cnt_r == WB_FULL);
  wire ready = ~rdy_n_i | ~burst_ready_n_i;
  wire req_live = req_valid_i & ~req_ack_o & ~wait_r;

  reg [3:0]  done;
  reg [3:0]  nrem;
  reg [31:0] rd_merge;
  reg        beat_ok;
  reg        filling;
  reg        end_now;
  reg        next_word;
  reg        bus_free;
  reg        rd_cache;
  reg        rd_bus_ok;
  reg        wr_only_direct;
  reg        wr_stall_go;
  reg        wr_post_direct;
  reg        wr_push;
  reg        wb_issue;
  reg        start;
  reg        st_wr;
  reg        hold_nxt;
  reg        float_nxt;

  always @*
  begin
    // previous-clock width sample decides the split
    if (w8_r)
      done = rem_r & (~rem_r + 4'h1);
    else if (w16_r)
      done = (|rem_r[1:0]) ? (rem_r & `LANES_LO16) : (rem_r & `LANES_HI16);
    else
      done = rem_r;
    nrem = rem_r & ~done;
    for (i = 0; i < 4; i = i + 1)
      rd_merge[8*i +: 8] = done[i] ? data_i[8*i +: 8] : rd_acc_r[8*i +: 8];
    // backoff outranks ready; data under backoff is dropped
    beat_ok = (bus_st_r == ST_ACT) & backoff_n_i & ~backoff_n_r & ready;
    // cacheable input taken at the end of the first word
    filling = (word_r == 2'h0) ? (fillc_r & ~line_cacheable_n_i) : fill_r;
    next_word = beat_ok & (nrem == `LANES_NONE) & filling & (word_r != `LINE_LAST_WORD);
    end_now = beat_ok & (nrem == `LANES_NONE) & ~next_word;
    bus_free = (bus_st_r == ST_IDLE) & ~hold_i & ~hold_o_busy(hold_ack_o) & backoff_n_i & ~addr_float_req_i;
    // locked reads never look in the cache
    rd_cache = req_live & ~req_write_i & ~req_lock_i & req_hit;
    // reorder only for an unlocked memory read miss past all-hit writes, once per drain
    rd_bus_ok = req_live & ~req_write_i & ~rd_cache & bus_free & ~bus_lock_o &
                (wb_empty | (~req_io_i & ~req_lock_i & (miss_cnt_r == {(WB_PTR_W+1){1'b0}}) & ~reorder_used_r));
    wr_only_direct = (req_io_i & ~req_rep_io_i) | req_lock_i;
    wr_stall_go = req_live & req_write_i & wr_only_direct & wb_empty & bus_free;
    wr_post_direct = req_live & req_write_i & ~wr_only_direct & wb_empty & bus_free & ~bus_lock_o;
    wr_push = req_live & req_write_i & ~wr_only_direct & ~wb_full & ~wr_post_direct;
    wb_issue = bus_free & ~wb_empty & ~rd_bus_ok & ~bus_lock_o;
    start = rd_bus_ok | wr_stall_go | wr_post_direct | wb_issue;
    st_wr = wb_issue | wr_stall_go | wr_post_direct;
    // a locked sequence is never split by a hold grant
    hold_nxt = hold_i & (bus_st_r == ST_IDLE) & ~bus_lock_o & ~start;
    float_nxt = hold_nxt | ~backoff_n_i;
  end

  function hold_o_busy;
    input h;
    begin
      hold_o_busy = h;
    end
  endfunction

  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      bus_st_r <= ST_IDLE;
      valid_r <= {LINES{1'b0}};
      wb_rd_r <= {WB_PTR_W{1'b0}};
      wb_wr_r <= {WB_PTR_W{1'b0}};
      wb_cnt_r <= {(WB_PTR_W+1){1'b0}};
      miss_cnt_r <= {(WB_PTR_W+1){1'b0}};
      reorder_used_r <= 1'b0;
      w8_r <= 1'b0;
      w16_r <= 1'b0;
      backoff_n_r <= 1'b0;
      wait_r <= 1'b0;
      rem_r <= `LANES_NONE;
      word_r <= 2'h0;
      fill_r <= 1'b0;
      fillc_r <= 1'b0;
      cur_ack_r <= 1'b0;
      cur_lockw_r <= 1'b0;
      rd_acc_r <= 32'h0;
      req_ack_o <= 1'b0;
      rd_hit_o <= 1'b0;
      rd_data_o <= 32'h0;
      cache_update_o <= 1'b0;
      ads_o <= 1'b0;
      addr_o <= 30'h0;
      addr_oe_o <= 1'b0;
      be_o <= `LANES_NONE;
      wr_o <= 1'b0;
      mem_io_o <= 1'b0;
      data_o <= 32'h0;
      data_oe_o <= 1'b0;
      bus_lock_o <= 1'b0;
      page_write_through_o <= 1'b0;
      page_cache_disable_o <= 1'b0;
      attr_oe_o <= 1'b0;
      hold_ack_o <= 1'b0;
    end
    else
    begin
      w8_r <= ~bus_width8_n_i;
      w16_r <= ~bus_width16_n_i & bus_width8_n_i;
      ads_o <= 1'b0;
      req_ack_o <= 1'b0;
      rd_hit_o <= 1'b0;
      cache_update_o <= 1'b0;
      hold_ack_o <= hold_nxt;
      addr_oe_o <= ~float_nxt & ~addr_float_req_i;
      attr_oe_o <= ~float_nxt;
      data_oe_o <= ~float_nxt & ((start & st_wr) | ((bus_st_r == ST_ACT) & ~end_now & wr_o));
      if (rd_cache)
      begin
        req_ack_o <= 1'b1;
        rd_hit_o <= 1'b1;
      end
      if ((wr_push | wr_post_direct | wr_stall_go) & req_hit)
        cache_update_o <= 1'b1;
      if (wr_push | wr_post_direct)
        req_ack_o <= 1'b1;
      if (wr_push)
      begin
        wb_addr[wb_wr_r] <= req_pa[31:2];
        wb_data[wb_wr_r] <= req_data_i;
        wb_be[wb_wr_r] <= req_be_i;
        wb_attr[wb_wr_r] <= {req_io_i, req_hit, pcd_req, pwt_req};
        wb_wr_r <= wb_wr_r + {{(WB_PTR_W-1){1'b0}}, 1'b1};
      end
      // cycle start; attributes launch with the address, like cycle definition
      if (start)
      begin
        bus_st_r <= ST_ACT;
        ads_o <= 1'b1;
        word_r <= 2'h0;
        fill_r <= 1'b0;
        backoff_n_r <= 1'b0;
        rd_acc_r <= 32'h0;
        wr_o <= st_wr;
        cur_ack_r <= ~wb_issue & ~wr_post_direct;
        cur_lockw_r <= wr_stall_go & req_lock_i;
        if (wb_issue)
        begin
          // head of queue leaves first
          addr_o <= wb_addr[wb_rd_r];
          data_o <= wb_data[wb_rd_r];
          be_o <= wb_be[wb_rd_r];
          rem_r <= wb_be[wb_rd_r];
          mem_io_o <= ~wb_attr[wb_rd_r][3];
          page_cache_disable_o <= wb_attr[wb_rd_r][1];
          page_write_through_o <= wb_attr[wb_rd_r][0];
          fillc_r <= 1'b0;
        end
        else
        begin
          addr_o <= req_pa[31:2];
          data_o <= req_data_i;
          mem_io_o <= ~req_io_i;
          page_cache_disable_o <= pcd_req;
          page_write_through_o <= pwt_req;
          fillc_r <= rd_bus_ok & ~req_io_i & ~req_lock_i & ~pcd_req;
          wait_r <= ~wr_post_direct;
          if (rd_bus_ok & ~req_io_i & ~req_lock_i & ~pcd_req)
          begin
            be_o <= `LANES_ALL;
            rem_r <= `LANES_ALL;
          end
          else
          begin
            be_o <= req_be_i;
            rem_r <= req_be_i;
          end
          if (rd_bus_ok & req_lock_i)
            bus_lock_o <= 1'b1;
          if (rd_bus_ok & ~wb_empty)
            reorder_used_r <= 1'b1;
        end
      end
      else if (bus_st_r == ST_ACT)
      begin
        if (~backoff_n_i)
          backoff_n_r <= 1'b1;
        else if (backoff_n_r)
        begin
          // aborted transfer restarts from its first remaining lane
          backoff_n_r <= 1'b0;
          ads_o <= 1'b1;
        end
        else if (beat_ok)
        begin
          rd_acc_r <= rd_merge;
          if (nrem != `LANES_NONE)
          begin
            rem_r <= nrem;
            be_o <= nrem;
            ads_o <= 1'b1;
          end
          else
          begin
            if ((word_r == 2'h0) & ~wr_o & cur_ack_r)
            begin
              req_ack_o <= 1'b1;
              rd_data_o <= rd_merge;
              wait_r <= 1'b0;
            end
            if (next_word)
            begin
              // words of the line run back to back
              fill_r <= 1'b1;
              word_r <= word_r + 2'h1;
              addr_o <= {addr_o[31:4], addr_o[3:2] + 2'h1};
              rem_r <= `LANES_ALL;
              be_o <= `LANES_ALL;
              ads_o <= 1'b1;
            end
            else
            begin
              bus_st_r <= ST_IDLE;
              wr_o <= 1'b0;
              if (filling)
              begin
                valid_r[cur_idx] <= 1'b1;
                tag_mem[cur_idx] <= addr_o[31:4+IDX_W];
              end
              if (cur_lockw_r)
                bus_lock_o <= 1'b0;
              if (wr_o & cur_ack_r)
              begin
                req_ack_o <= 1'b1;
                wait_r <= 1'b0;
              end
            end
          end
        end
      end
      if (~wb_empty & (start & wb_issue))
        wb_rd_r <= wb_rd_r + {{(WB_PTR_W-1){1'b0}}, 1'b1};
      case ({wr_push, start & wb_issue})
        2'b10: wb_cnt_r <= wb_cnt_r + {{WB_PTR_W{1'b0}}, 1'b1};
        2'b01: wb_cnt_r <= wb_cnt_r - {{WB_PTR_W{1'b0}}, 1'b1};
        default: wb_cnt_r <= wb_cnt_r;
      endcase
      case ({wr_push & ~req_hit, start & wb_issue & ~wb_attr[wb_rd_r][2]})
        2'b10: miss_cnt_r <= miss_cnt_r + {{WB_PTR_W{1'b0}}, 1'b1};
        2'b01: miss_cnt_r <= miss_cnt_r - {{WB_PTR_W{1'b0}}, 1'b1};
        default: miss_cnt_r <= miss_cnt_r;
      endcase
      if (wb_empty & ~(rd_bus_ok & ~wb_empty))
        reorder_used_r <= 1'b0;
      // flush, or a snoop matching the old entry, wins over a fill landing in the same clock
      if (sn_hit)
        valid_r[sn_idx] <= 1'b0;
      if (~flush_n_i)
        valid_r <= {LINES{1'b0}};
    end
  end
endmodule

// file: test/bus_partner.sv
// far-side memory model: answers each beat after a set number of waits
// assumes one beat in flight at a time, ads_o marking each beat start
`timescale 1ns/1ps
module bus_partner (
  input  wire        ref_clk_i,
  input  wire        sys_rst_i,
  input  wire        ads_o,
  input  wire        wr_o,
  input  wire [31:2] addr_o,
  input  wire [31:0] data_o,
  input  wire [1:0]  wait_i,
  input  wire        cacheable_i,
  output reg         rdy_n_i = 1'b1,
  output wire        burst_ready_n_i,
  output wire        line_cacheable_n_i,
  output reg  [31:0] data_i = 32'h0
);
  reg          busy_r;
  reg          wr_r;
  reg  [1:0]   cnt_r;
  reg  [31:2]  a_r;
  reg  [31:0]  d_r;
  integer      n_beat = 0;
  logic [31:0] alog[$];
  logic [31:0] dlog[$];
  wire [1:0]   left = ads_o ? wait_i : cnt_r;
  wire [31:2]  cur_a = ads_o ? addr_o : a_r;
  assign burst_ready_n_i = 1'b1;
  assign line_cacheable_n_i = ~cacheable_i;
  always @(posedge ref_clk_i)
  begin
    rdy_n_i <= 1'b1;
    // released bus inverts the word it showed on the clock before
    data_i <= ~data_i;
    if (sys_rst_i)
      busy_r <= 1'b0;
    else if (ads_o || busy_r)
    begin
      if (ads_o)
      begin
        a_r <= addr_o;
        wr_r <= wr_o;
        d_r <= data_o;
        n_beat <= n_beat + 1;
      end
      cnt_r <= left - 2'h1;
      busy_r <= (left != 2'h0);
      if (left == 2'h0)
      begin
        rdy_n_i <= 1'b0;
        data_i <= {cur_a, 2'h0} ^ 32'h5a5a0000;
        if (ads_o ? wr_o : wr_r)
        begin
          alog.push_back({cur_a, 2'h0});
          dlog.push_back(ads_o ? data_o : d_r);
        end
      end
    end
  end
endmodule

// file: test/cache_ctl_write_buffer_asserts.sv
// port checker for the cache control and write buffer block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module cache_ctl_write_buffer_chk (
  input wire        ref_clk_i,
  input wire        sys_rst_i,
  input wire        req_write_i,
  input wire        req_io_i,
  input wire        req_rep_io_i,
  input wire        req_lock_i,
  input wire        cache_enable_i,
  input wire        addr20_mask_n_i,
  input wire        rdy_n_i,
  input wire        burst_ready_n_i,
  input wire        addr_float_req_i,
  input wire        req_ack_o,
  input wire        rd_hit_o,
  input wire        ads_o,
  input wire        wr_o,
  input wire        data_oe_o,
  input wire [31:2] addr_o,
  input wire        addr_oe_o,
  input wire [3:0]  be_o,
  input wire        mem_io_o,
  input wire        bus_lock_o,
  input wire        page_cache_disable_o,
  input wire        attr_oe_o,
  input wire        hold_ack_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  addr_float_a:
    assert property (addr_float_req_i |=> !addr_oe_o) else $error("address still driven");
  no_start_a:
    assert property (addr_float_req_i && $past(addr_float_req_i) |-> !ads_o) else $error("start in hold");
  attr_float_a:
    assert property (hold_ack_o |-> !attr_oe_o && !ads_o) else $error("attrs driven in hold");
  pcd_force_a:
    assert property (ads_o && !cache_enable_i && $past(!cache_enable_i) |-> page_cache_disable_o)
      else $error("cache disable not forced");
  bit20_mask_a:
    assert property (ads_o && mem_io_o && !addr20_mask_n_i |-> !addr_o[20]) else $error("bit 20 not masked");
  beat_lanes_a:
    assert property (ads_o |-> be_o != 4'h0) else $error("beat without lanes");
  io_stall_a:
    assert property (req_ack_o && req_io_i && req_write_i && !req_rep_io_i |-> $past(!rdy_n_i || !burst_ready_n_i))
      else $error("output write acked early");
  lock_bypass_a:
    assert property (req_ack_o && req_lock_i && !req_write_i |-> !rd_hit_o) else $error("locked read hit");
  lock_hold_a:
    assert property (bus_lock_o |-> !hold_ack_o) else $error("bus granted while locked");
  wr_drive_a:
    assert property (ads_o |-> data_oe_o == wr_o) else $error("data drive does not match direction");
endmodule
bind cache_ctl_write_buffer cache_ctl_write_buffer_chk cache_ctl_write_buffer_chk_inst (.ref_clk_i, .sys_rst_i,
  .req_write_i, .req_io_i, .req_rep_io_i, .req_lock_i, .cache_enable_i, .addr20_mask_n_i, .rdy_n_i,
  .burst_ready_n_i, .addr_float_req_i, .req_ack_o, .rd_hit_o, .ads_o, .addr_o, .addr_oe_o, .be_o, .mem_io_o,
  .bus_lock_o, .page_cache_disable_o, .attr_oe_o, .hold_ack_o, .wr_o, .data_oe_o);

// file: test/cache_ctl_write_buffer_tb_top.sv
// self-checking bench for the cache control and write buffer block
// assumes bus_partner on the far side and the bound port checker
`timescale 1ns/1ps
module cache_ctl_write_buffer_tb_top;
  reg ref_clk_i = 0, sys_rst_i = 1, req_valid_i = 0, req_write_i = 0, req_io_i = 0, req_rep_io_i = 0;
  reg req_lock_i = 0, paging_en_i = 0, cache_enable_i = 1, addr20_mask_n_i = 1, flush_n_i = 1;
  reg backoff_n_i = 1, hold_i = 0, addr_float_req_i = 0, snoop_addr_strobe_n_i = 1, cach_r = 1, hit;
  reg bus_width16_n_i = 1, bus_width8_n_i = 1;
  reg [1:0] wait_r = 0, attr_s;
  reg [3:0] req_be_i = 4'hf;
  reg [4:0] pte_flags_i = 0, page_base_flags_i = 0;
  reg [31:4] snoop_addr_i = 0;
  reg [31:0] req_addr_i = 0, req_data_i = 0, rdat;
  wire rdy_n_i, burst_ready_n_i, line_cacheable_n_i, req_ack_o, rd_hit_o, cache_update_o, ads_o, addr_oe_o;
  wire wr_o, mem_io_o, data_oe_o, bus_lock_o, page_write_through_o, page_cache_disable_o, attr_oe_o, hold_ack_o;
  wire [31:0] data_i, rd_data_o, data_o;
  wire [31:2] addr_o;
  wire [3:0] be_o;
  integer n_mismatch = 0, num_checks = 0, i, b0, n0, n_upd = 0;
  cache_ctl_write_buffer cache_ctl_write_buffer_inst (.*);
  bus_partner bus_partner_inst (.ref_clk_i, .sys_rst_i, .ads_o, .wr_o, .addr_o, .data_o, .wait_i(wait_r),
    .cacheable_i(cach_r), .rdy_n_i, .burst_ready_n_i, .line_cacheable_n_i, .data_i);
  always #25 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (ads_o) attr_s <= {page_write_through_o, page_cache_disable_o};
  // update is a one-cycle pulse at acceptance, so count it rather than sample it at ack
  always @(posedge ref_clk_i) if (cache_update_o) n_upd <= n_upd + 1;
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // one core request held until acknowledged, then one quiet edge
  task rq(input w, input io, input lk, input [31:0] a, input [31:0] d);
    integer k;
  begin
    req_valid_i <= 1; req_write_i <= w; req_io_i <= io; req_lock_i <= lk; req_addr_i <= a; req_data_i <= d;
    k = 0;
    @(posedge ref_clk_i);
    while (req_ack_o !== 1'b1 && k < 500)
    begin
      @(posedge ref_clk_i);
      k = k + 1;
    end
    hit = rd_hit_o;
    rdat = rd_data_o;
    req_valid_i <= 0;
    if (k == 500) chk(0, 1);
    @(posedge ref_clk_i);
  end
  endtask
  task final_report;
  begin
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // about 400 cycles expected; allow twenty times that
  initial
  begin
    #400000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial
  begin
    idle(8);
    sys_rst_i <= 0;
    idle(1);
    chk({ads_o, req_ack_o, bus_lock_o}, 0);
    b0 = bus_partner_inst.n_beat;
    rq(0, 0, 0, 32'h100, 0); chk(rdat, 32'h5a5a0100);
    idle(20); chk(bus_partner_inst.n_beat - b0, 4);
    rq(0, 0, 0, 32'h10c, 0); chk(hit, 1);
    $display("test fill done");
    b0 = bus_partner_inst.n_beat;
    hold_i <= 1; addr_float_req_i <= 1; idle(3);
    chk(hold_ack_o, 1);
    snoop_addr_i <= 28'h10; snoop_addr_strobe_n_i <= 0; idle(1);
    snoop_addr_strobe_n_i <= 1; idle(2);
    hold_i <= 0; addr_float_req_i <= 0; idle(3);
    chk(bus_partner_inst.n_beat - b0, 0);
    rq(0, 0, 0, 32'h104, 0); chk(hit, 0);
    idle(20);
    flush_n_i <= 0; idle(1); flush_n_i <= 1; idle(1);
    rq(0, 0, 0, 32'h108, 0); chk(hit, 0);
    idle(20);
    $display("test invalidate done");
    paging_en_i <= 1; pte_flags_i <= 5'h10; idle(2);
    rq(0, 0, 0, 32'h200, 0); idle(8); chk(attr_s, 2'b01);
    rq(0, 0, 0, 32'h204, 0); chk(hit, 0);
    for (i = 0; i < 3; i = i + 1)
    begin
      {paging_en_i, cache_enable_i, pte_flags_i, page_base_flags_i} <= i == 0 ? 12'hd10 : i == 1 ? 12'h510 : 12'h900;
      idle(2);
      rq(1, 0, 0, 32'h300, i); idle(8);
      chk(attr_s, i == 0 ? 2'b10 : i == 1 ? 2'b01 : 2'b11);
    end
    {paging_en_i, cache_enable_i, pte_flags_i, page_base_flags_i} <= 12'h400;
    $display("test attributes done");
    wait_r <= 2'h3; idle(2);
    n0 = bus_partner_inst.dlog.size();
    b0 = bus_partner_inst.n_beat;
    for (i = 0; i < 4; i = i + 1)
    begin
      rq(1, 0, 0, 32'h400 + 4 * i, i + 1);
      if (i == 0) chk(bus_partner_inst.dlog.size(), n0);
      if (i == 0) chk(bus_partner_inst.n_beat - b0, 1);
    end
    idle(40);
    for (i = 0; i < 4; i = i + 1) chk(bus_partner_inst.dlog[n0 + i], i + 1);
    rq(1, 1, 0, 32'h60, 32'h77); chk(bus_partner_inst.dlog.size(), n0 + 5);
    wait_r <= 2'h0; idle(2);
    $display("test write buffer done");
    for (i = 0; i < 3; i = i + 1)
    begin
      {bus_width16_n_i, bus_width8_n_i} <= i[1:0]; idle(2);
      b0 = bus_partner_inst.n_beat;
      rq(1, 0, 0, 32'h600, 0); idle(12);
      chk(bus_partner_inst.n_beat - b0, i == 1 ? 2 : 4);
    end
    b0 = bus_partner_inst.n_beat;
    rq(0, 0, 0, 32'h700, 0); idle(50); chk(bus_partner_inst.n_beat - b0, 16);
    {bus_width16_n_i, bus_width8_n_i} <= 2'b11;
    // mask only raised while the core is taken to be in real mode
    addr20_mask_n_i <= 0; idle(2);
    rq(1, 0, 0, 32'h100010, 1); idle(10);
    chk(bus_partner_inst.alog[bus_partner_inst.alog.size() - 1], 32'h10);
    addr20_mask_n_i <= 1;
    $display("test sizing done");
    // line 0x700 is cached by the narrow fill above, so a plain read must hit
    rq(0, 0, 0, 32'h708, 0); chk(hit, 1);
    rq(0, 0, 1, 32'h704, 0); chk(hit, 0);
    chk(bus_lock_o, 1);
    b0 = n_upd;
    rq(1, 0, 1, 32'h704, 9); idle(4); chk(bus_lock_o, 0);
    chk(n_upd - b0, 1);
    $display("test lock done");
    // slow partner keeps hit writes queued while a miss read arrives
    wait_r <= 2'h3; idle(2);
    rq(1, 0, 0, 32'h700, 1); rq(1, 0, 0, 32'h704, 2); rq(1, 0, 0, 32'h708, 3);
    rq(0, 0, 0, 32'h810, 0); chk(bus_partner_inst.alog[bus_partner_inst.alog.size() - 1], 32'h704);
    rq(0, 0, 0, 32'h820, 0); chk(bus_partner_inst.alog[bus_partner_inst.alog.size() - 1], 32'h708);
    $display("test reorder done");
    final_report;
  end
endmodule
